/* logic/rbag_core.v */
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "rbag_defines.vh"

// Operation
// - Indexed aux pointer: base plus offset, unchanged
// - Long offset sign-extended from 16 to 23
// - Long offset operand refused when paralleled
// - Pre-modify: pointer updated, then address formed
// - Short offset 1..7 zero-extended, pointer unchanged
// - Coefficient pointer: 7 high, 16 low bits
// - Pair test copies two bits to flags
// - Clear exactly the addressed accumulator bit
// - Set exactly the addressed accumulator bit
module rbag_core (
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // Operation request from decode
  input wire op_valid_i,
  input wire [1:0] op_kind_i,
  input wire [1:0] op_mode_i,
  input wire [1:0] op_ptr_sel_i,
  input wire [1:0] op_acc_sel_i,
  input wire [15:0] op_offset_i,
  input wire op_parallel_i,
  // Operation result
  output reg op_done_o,
  output reg op_refused_o,
  output reg [22:0] bit_addr_o,
  output wire test_flag_one_o,
  output wire test_flag_two_o,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o
);

  reg [22:0] extended_aux_pointer_r [0:3];
  reg [39:0] acc_r [0:3];
  reg [22:0] extended_coefficient_pointer_r;
  reg [15:0] circular_buffer_start_address_r;
  reg [15:0] coefficient_buffer_start_address_r;
  reg [4:0] circ_r;
  reg test_flag_one_r;
  reg test_flag_two_r;
  wire [22:0] sel_ptr;
  wire [22:0] off_ext;
  wire [22:0] pre_ptr;
  wire [22:0] calc_base;
  wire [22:0] calc_off;
  wire [22:0] gen_addr;
  wire sel_circ;
  wire [15:0] sel_start;
  wire is_long;
  wire is_cdp;
  wire refuse;
  wire go;
  wire [5:0] bit_a;
  wire [22:0] addr_b;
  wire [5:0] bit_b;
  wire in_a;
  wire in_b;
  wire [39:0] sel_acc;
  wire [6:0] coefficient_pointer_high;
  wire [15:0] coefficient_pointer_low;

  // Split view of the coefficient pointer
  assign coefficient_pointer_high = extended_coefficient_pointer_r[22:16];
  assign coefficient_pointer_low = extended_coefficient_pointer_r[15:0];

  // Operand decode
  assign is_long = (op_mode_i == `RBAG_MD_LONG) ||
                   (op_mode_i == `RBAG_MD_PRE);
  assign is_cdp = (op_mode_i == `RBAG_MD_CDP);
  assign sel_ptr = is_cdp ?
    {coefficient_pointer_high, coefficient_pointer_low} :
    extended_aux_pointer_r[op_ptr_sel_i];

  // Offset extension per operand form
  assign off_ext = is_long ? {{7{op_offset_i[15]}}, op_offset_i} :
                   (op_mode_i == `RBAG_MD_SHORT) ?
                   {20'h0_0000, op_offset_i[2:0]} :
                   23'h00_0000;

  // Pre-modified pointer over the full 23 bits
  assign pre_ptr = sel_ptr + off_ext;

  // Circular selection per pointer in use
  assign sel_circ = is_cdp ? circ_r[`RBAG_CIRC_CDP] :
                    circ_r[op_ptr_sel_i];
  assign sel_start = is_cdp ? coefficient_buffer_start_address_r :
                     circular_buffer_start_address_r;

  // Pre-modify uses the updated pointer with no further offset
  assign calc_base = (op_mode_i == `RBAG_MD_PRE) ? pre_ptr : sel_ptr;
  assign calc_off = (op_mode_i == `RBAG_MD_PRE) ? 23'h00_0000 : off_ext;

  rbag_addr_calc u_calc (
    .base_i(calc_base),
    .offset_i(calc_off),
    .circ_i(sel_circ),
    .start_i(sel_start),
    .addr_o(gen_addr)
  );

  // Refusal: paralleled long offset, zero short offset, unknown op
  assign refuse = op_valid_i & ((is_long & op_parallel_i) |
                  ((op_mode_i == `RBAG_MD_SHORT) &&
                   (op_offset_i[2:0] == 3'h0)) |
                  (op_kind_i == 2'h3));
  assign go = op_valid_i & ~refuse;

  // Bit positions within the selected accumulator
  assign bit_a = gen_addr[5:0];
  // Second address is a full 23-bit increment, so bit 63 never wraps to 0
  assign addr_b = gen_addr + 23'h00_0001;
  assign bit_b = addr_b[5:0];
  assign in_a = (gen_addr[22:6] == 17'h0_0000) && (bit_a < `RBAG_ACC_BITS);
  assign in_b = (addr_b[22:6] == 17'h0_0000) && (bit_b < `RBAG_ACC_BITS);
  assign sel_acc = acc_r[op_acc_sel_i];

  // Per-entry pointer and accumulator storage
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ent
      // Entry index and register addresses, cut to the port widths
      localparam integer ent_idx = gi;
      localparam integer xar_addr = `RBAG_XAR_BASE + 4 * gi;
      localparam integer acc_lo_addr = `RBAG_ACC_BASE + 8 * gi;
      localparam integer acc_hi_addr = acc_lo_addr + 4;
      // Pointer: bus write, pre-modify writeback wins
      always @(posedge core_clk_i) begin
        if (srst_i) begin
          extended_aux_pointer_r[gi] <= `RBAG_PTR_RST;
        end else if (go && (op_mode_i == `RBAG_MD_PRE) &&
                     (op_ptr_sel_i == ent_idx[1:0])) begin
          extended_aux_pointer_r[gi] <= pre_ptr;
        end else if (reg_wr_i && (reg_addr_i == xar_addr[7:0])) begin
          extended_aux_pointer_r[gi] <= reg_wdata_i[22:0];
        end
      end
      // Accumulator: single-bit set or clear, bus write otherwise
      always @(posedge core_clk_i) begin
        if (srst_i) begin
          acc_r[gi] <= `RBAG_ACC_RST;
        end else if (go && (op_acc_sel_i == ent_idx[1:0]) && in_a &&
                     (op_kind_i == `RBAG_OP_SET)) begin
          acc_r[gi][bit_a] <= 1'b1;
        end else if (go && (op_acc_sel_i == ent_idx[1:0]) && in_a &&
                     (op_kind_i == `RBAG_OP_CLR)) begin
          acc_r[gi][bit_a] <= 1'b0;
        end else if (reg_wr_i && (reg_addr_i == acc_lo_addr[7:0])) begin
          acc_r[gi][31:0] <= reg_wdata_i;
        end else if (reg_wr_i && (reg_addr_i == acc_hi_addr[7:0])) begin
          acc_r[gi][39:32] <= reg_wdata_i[7:0];
        end
      end
    end
  endgenerate

  // Shared configuration registers
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      extended_coefficient_pointer_r <= `RBAG_PTR_RST;
      circular_buffer_start_address_r <= `RBAG_BSA_RST;
      coefficient_buffer_start_address_r <= `RBAG_BSA_RST;
      circ_r <= `RBAG_CIRC_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `RBAG_EXTENDED_COEFFICIENT_POINTER)
        extended_coefficient_pointer_r <= reg_wdata_i[22:0];
      if (reg_addr_i == `RBAG_BSA)
        circular_buffer_start_address_r <= reg_wdata_i[15:0];
      if (reg_addr_i == `RBAG_COEFFICIENT_BUFFER_START_ADDRESS)
        coefficient_buffer_start_address_r <= reg_wdata_i[15:0];
      if (reg_addr_i == `RBAG_CIRC)
        circ_r <= reg_wdata_i[4:0];
    end
  end

  // Status flags: a pair test wins over a bus write
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      test_flag_one_r <= 1'b0;
      test_flag_two_r <= 1'b0;
    end else if (go && (op_kind_i == `RBAG_OP_TST)) begin
      test_flag_one_r <= in_a & sel_acc[bit_a];
      test_flag_two_r <= in_b & sel_acc[bit_b];
    end else if (reg_wr_i && (reg_addr_i == `RBAG_ST0)) begin
      test_flag_one_r <= reg_wdata_i[`RBAG_ST0_TC1];
      test_flag_two_r <= reg_wdata_i[`RBAG_ST0_TC2];
    end
  end

  assign test_flag_one_o = test_flag_one_r;
  assign test_flag_two_o = test_flag_two_r;

  // Result strobes and the generated address
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      op_done_o <= 1'b0;
      op_refused_o <= 1'b0;
      bit_addr_o <= `RBAG_PTR_RST;
    end else begin
      op_done_o <= go;
      op_refused_o <= refuse;
      if (go)
        bit_addr_o <= gen_addr;
    end
  end

  // Register read, data in the following cycle
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      case (reg_addr_i)
        8'h00, 8'h04, 8'h08, 8'h0C:
          reg_rdata_o <= {9'h000, extended_aux_pointer_r[reg_addr_i[3:2]]};
        `RBAG_EXTENDED_COEFFICIENT_POINTER:
          reg_rdata_o <= {9'h000, extended_coefficient_pointer_r};
        `RBAG_BSA:
          reg_rdata_o <= {16'h0000, circular_buffer_start_address_r};
        `RBAG_COEFFICIENT_BUFFER_START_ADDRESS:
          reg_rdata_o <= {16'h0000, coefficient_buffer_start_address_r};
        `RBAG_CIRC:
          reg_rdata_o <= {27'h000_0000, circ_r};
        `RBAG_ST0:
          reg_rdata_o <= {30'h0000_0000, test_flag_two_r, test_flag_one_r};
        8'h40, 8'h48, 8'h50, 8'h58:
          reg_rdata_o <= acc_r[reg_addr_i[4:3]][31:0];
        8'h44, 8'h4C, 8'h54, 8'h5C:
          reg_rdata_o <= {24'h00_0000, acc_r[reg_addr_i[4:3]][39:32]};
        default:
          reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // rbag_core

/* shared/rbag_defines.vh */
`ifndef RBAG_DEFINES_VH
`define RBAG_DEFINES_VH

// Datapath widths
`define RBAG_PTR_W 23
`define RBAG_ACC_W 40
`define RBAG_ACC_BITS 6'h28
`define RBAG_NUM_PTR 4
`define RBAG_NUM_ACC 4

// Register byte addresses
`define RBAG_XAR_BASE 8'h00
`define RBAG_EXTENDED_COEFFICIENT_POINTER 8'h10
`define RBAG_BSA 8'h14
`define RBAG_COEFFICIENT_BUFFER_START_ADDRESS 8'h18
`define RBAG_CIRC 8'h1C
`define RBAG_ST0 8'h20
`define RBAG_ACC_BASE 8'h40

// Field positions
`define RBAG_ST0_TC1 0
`define RBAG_ST0_TC2 1
`define RBAG_CIRC_CDP 4

// Reset values
`define RBAG_PTR_RST 23'h00_0000
`define RBAG_ACC_RST 40'h00_0000_0000
`define RBAG_BSA_RST 16'h0000
`define RBAG_CIRC_RST 5'h00

// Bit operations
`define RBAG_OP_SET 2'h0
`define RBAG_OP_CLR 2'h1
`define RBAG_OP_TST 2'h2

// Operand forms
`define RBAG_MD_LONG 2'h0
`define RBAG_MD_PRE 2'h1
`define RBAG_MD_SHORT 2'h2
`define RBAG_MD_CDP 2'h3

`endif

/* logic/rbag_addr_calc.v */
`timescale 1ns/1ps
`include "rbag_defines.vh"

module rbag_addr_calc (
  // Pointer and offset
  input wire [22:0] base_i,
  input wire [22:0] offset_i,
  // Circular addressing
  input wire circ_i,
  input wire [15:0] start_i,
  // Generated bit address
  output wire [22:0] addr_o
);

  wire [22:0] lin_sum;
  wire [15:0] circ_sum;

  // Linear form adds across all 23 bits
  assign lin_sum = base_i + offset_i;
  // Circular form keeps the high part and wraps the low 16 bits
  assign circ_sum = start_i + base_i[15:0] + offset_i[15:0];
  assign addr_o = circ_i ? {base_i[22:16], circ_sum} : lin_sum;

endmodule // rbag_addr_calc

/* verif/rbag_checker.sv */
`timescale 1ns/1ps
`include "rbag_defines.vh"
module rbag_checker (
  // Clock and reset
  input logic core_clk_i,
  input logic srst_i,
  // Operation request
  input logic op_valid_i,
  input logic [1:0] op_kind_i,
  input logic [1:0] op_mode_i,
  input logic [1:0] op_ptr_sel_i,
  input logic [1:0] op_acc_sel_i,
  input logic [15:0] op_offset_i,
  input logic op_parallel_i,
  // Operation result
  input logic op_done_o,
  input logic op_refused_o,
  input logic [22:0] bit_addr_o,
  input logic test_flag_one_o,
  input logic test_flag_two_o,
  // Register port
  input logic [7:0] reg_addr_i,
  input logic [31:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  input logic [31:0] reg_rdata_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Request classes
  logic par_bad, short_bad, good, tst_req, st0_wr;
  logic [1:0] flags;
  assign par_bad = !op_mode_i[1] && op_parallel_i;
  assign short_bad = op_mode_i == `RBAG_MD_SHORT && op_offset_i[2:0] == 3'h0;
  assign good = op_valid_i && op_kind_i != 2'h3 && !par_bad && !short_bad;
  assign tst_req = op_valid_i && op_kind_i == `RBAG_OP_TST;
  assign st0_wr = reg_wr_i && reg_addr_i == `RBAG_ST0;
  assign flags = {test_flag_two_o, test_flag_one_o};
  a_par_refused: assert property (
    op_valid_i && par_bad |=> op_refused_o && !op_done_o)
    else $error("parallel long offset op not refused");
  a_short_refused: assert property (
    op_valid_i && short_bad |=> op_refused_o && !op_done_o)
    else $error("zero short offset not refused");
  a_done_follows: assert property (
    good |=> op_done_o && !op_refused_o)
    else $error("accepted op gave no done pulse");
  a_idle_quiet: assert property (
    !op_valid_i |=> !op_done_o && !op_refused_o)
    else $error("answer without request");
  a_addr_hold: assert property (
    !op_done_o |-> $stable(bit_addr_o))
    else $error("bit address moved without an op");
  a_flag_cause: assert property (
    $changed(flags) |-> $past(tst_req) || $past(st0_wr))
    else $error("flags changed without test or write");
  a_setclr_flags: assert property (
    op_valid_i && !op_kind_i[1] && !reg_wr_i |=> $stable(flags))
    else $error("set or clear touched the flags");
  a_one_answer: assert property (
    !(op_done_o && op_refused_o))
    else $error("done and refused together");
  // Main scenarios
  c_test: cover property (tst_req);
  c_pre: cover property (good && op_mode_i == `RBAG_MD_PRE);
  c_refused: cover property (op_refused_o);
endmodule // rbag_checker
bind rbag_core rbag_checker chk (.*);

/* verif/register_bit_address_gen_bench.sv */
`timescale 1ns/1ps
`include "rbag_defines.vh"
module register_bit_address_gen_bench;
  // Stimulus and observed outputs
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic op_valid_i = 1'b0;
  logic op_parallel_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [1:0] op_kind_i = 2'h0;
  logic [1:0] op_mode_i = 2'h0;
  logic [1:0] op_ptr_sel_i = 2'h0;
  logic [1:0] op_acc_sel_i = 2'h0;
  logic [15:0] op_offset_i = 16'h0000;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic op_done_o, op_refused_o, test_flag_one_o, test_flag_two_o;
  logic [22:0] bit_addr_o;
  logic [31:0] reg_rdata_o;
  int err_count = 0;
  int comparisons = 0;
  // Clock
  always #5 core_clk_i = ~core_clk_i;
  rbag_core dut (.*);
  // Compare and report
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata_o);
  endtask
  // One bit operation and its answer
  task automatic op(input logic [1:0] k, m, p, c, input logic [15:0] f,
                    input logic par, rf, input logic [22:0] ad);
    @(posedge core_clk_i);
    op_valid_i <= 1'b1;
    op_kind_i <= k;
    op_mode_i <= m;
    op_ptr_sel_i <= p;
    op_acc_sel_i <= c;
    op_offset_i <= f;
    op_parallel_i <= par;
    @(posedge core_clk_i);
    op_valid_i <= 1'b0;
    #1 chk("op_refused_o", 32'(rf), 32'(op_refused_o));
    chk("op_done_o", 32'(!rf), 32'(op_done_o));
    if (!rf) chk("bit_addr_o", 32'(ad), 32'(bit_addr_o));
  endtask
  task automatic conclude();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0010);
    wr(8'h50, 32'hFFFF_FFFF);
    op(`RBAG_OP_CLR, `RBAG_MD_LONG, 2'h0, 2'h2, 16'h000F, 0, 0, 23'h1F);
    rd(8'h50, 32'h7FFF_FFFF);
    rd(8'h00, 32'h0000_0010);
    wr(8'h04, 32'h0000_0040);
    op(`RBAG_OP_SET, `RBAG_MD_LONG, 2'h1, 2'h3, 16'hFFD8, 0, 0, 23'h18);
    rd(8'h58, 32'h0100_0000);
    op(`RBAG_OP_SET, `RBAG_MD_LONG, 2'h1, 2'h3, 16'h0001, 1, 1, 23'h0);
    op(`RBAG_OP_SET, `RBAG_MD_PRE, 2'h1, 2'h3, 16'h0001, 1, 1, 23'h0);
    rd(8'h58, 32'h0100_0000);
    rd(8'h04, 32'h0000_0040);
    wr(8'h08, 32'h0000_0005);
    op(`RBAG_OP_SET, `RBAG_MD_PRE, 2'h2, 2'h1, 16'h0003, 0, 0, 23'h8);
    rd(8'h08, 32'h0000_0008);
    rd(8'h48, 32'h0000_0100);
    wr(8'h0C, 32'h0000_0010);
    op(`RBAG_OP_TST, `RBAG_MD_SHORT, 2'h3, 2'h2, 16'hFFF7, 1, 0, 23'h17);
    rd(`RBAG_ST0, 32'h0000_0003);
    op(`RBAG_OP_TST, `RBAG_MD_SHORT, 2'h3, 2'h2, 16'h0008, 0, 1, 23'h0);
    op(`RBAG_OP_TST, `RBAG_MD_LONG, 2'h0, 2'h2, 16'h000E, 0, 0, 23'h1E);
    chk("flags", 32'h0000_0001, 32'({test_flag_two_o, test_flag_one_o}));
    wr(`RBAG_EXTENDED_COEFFICIENT_POINTER, 32'h0012_3456);
    rd(`RBAG_EXTENDED_COEFFICIENT_POINTER, 32'h0012_3456);
    wr(`RBAG_EXTENDED_COEFFICIENT_POINTER, 32'h0000_0004);
    op(`RBAG_OP_SET, `RBAG_MD_CDP, 2'h0, 2'h0, 16'h0000, 0, 0, 23'h4);
    rd(8'h40, 32'h0000_0010);
    wr(`RBAG_COEFFICIENT_BUFFER_START_ADDRESS, 32'h0000_0020);
    wr(`RBAG_CIRC, 32'h0000_0010);
    op(`RBAG_OP_SET, `RBAG_MD_CDP, 2'h0, 2'h0, 16'h0000, 0, 0, 23'h24);
    rd(8'h44, 32'h0000_0010);
    rd(`RBAG_EXTENDED_COEFFICIENT_POINTER, 32'h0000_0004);
    // Illegal operation kind is refused
    op(2'h3, `RBAG_MD_CDP, 2'h0, 2'h0, 16'h0000, 0, 1, 23'h0);
    // Circular wrap stays in the low 16 bits, high part kept
    wr(`RBAG_EXTENDED_COEFFICIENT_POINTER, 32'h0001_FFFE);
    op(`RBAG_OP_SET, `RBAG_MD_CDP, 2'h0, 2'h0, 16'h0, 0, 0, 23'h1_001E);
    rd(8'h40, 32'h0000_0010);
    // Circular aux pointer adds its start address
    wr(`RBAG_BSA, 32'h0000_0008);
    wr(`RBAG_CIRC, 32'h0000_0011);
    op(`RBAG_OP_CLR, `RBAG_MD_SHORT, 2'h0, 2'h2, 16'h3, 0, 0, 23'h1B);
    rd(8'h50, 32'h77FF_FFFF);
    rd(8'h00, 32'h0000_0010);
    // Pair test at bit 63: neither address lands in the accumulator
    wr(8'h40, 32'h0000_0011);
    op(`RBAG_OP_TST, `RBAG_MD_LONG, 2'h3, 2'h0, 16'h002F, 0, 0, 23'h3F);
    chk("flags", 32'h0000_0000, 32'({test_flag_two_o, test_flag_one_o}));
    conclude();
  end
endmodule // register_bit_address_gen_bench
